/* hw/pue_defs.svh */
// Constants of the user error reporting block
//
// Function
// - Malformed without AER sends fatal message
// - AER on: severity picks non-fatal or fatal
// - AER off: multicast/poisoned-norecover send non-fatal
// - Poisoned recoverable is advisory, correctable with AER
// - Posted report sends non-fatal message
// - Ready low stops non-posted UR/CA reports
// - Disabled messages still set status bits
// - AER severity and mask steer messages
// - Completion timeout sends error message
// - Foreign requester ID completions dropped, flagged
// - Automatic unexpected completion sends no message
// - Header-logged holds until pointer status cleared
`ifndef PUE_DEFS_SVH
`define PUE_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PUE_ADDR_CTRL      8'h00
`define PUE_ADDR_DEV_ID    8'h04
`define PUE_ADDR_UNC_STAT  8'h08
`define PUE_ADDR_UNC_MASK  8'h0C
`define PUE_ADDR_UNC_SEV   8'h10
`define PUE_ADDR_COR_STAT  8'h14
`define PUE_ADDR_COR_MASK  8'h18
`define PUE_ADDR_ERR_CAP   8'h1C
`define PUE_ADDR_DEV_STAT  8'h20
`define PUE_ADDR_HDR_LOG0  8'h24
`define PUE_ADDR_HDR_LOG1  8'h28
`define PUE_ADDR_HDR_LOG2  8'h2C
`define PUE_ADDR_HDR_LOG3  8'h30

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define PUE_CTRL_AER_EN    0
`define PUE_CTRL_COR_EN    1
`define PUE_CTRL_NF_EN     2
`define PUE_CTRL_FAT_EN    3
`define PUE_CTRL_SERR_EN   4
`define PUE_CTRL_W         5

// ----------------------------------------------------------------
// Uncorrectable status bit positions and the advisory correctable bit
// ----------------------------------------------------------------
`define PUE_UNC_POISONED   5'h0C
`define PUE_UNC_CPL_TO     5'h0E
`define PUE_UNC_CPL_ABORT  5'h0F
`define PUE_UNC_UNEXP_CPL  5'h10
`define PUE_UNC_MALFORMED  5'h12
`define PUE_UNC_ECRC       5'h13
`define PUE_UNC_UNSUP_REQ  5'h14
`define PUE_UNC_MC_BLOCK   5'h17
`define PUE_COR_ADVISORY   5'h0D

// ----------------------------------------------------------------
// Device status bits and completion status codes
// ----------------------------------------------------------------
`define PUE_DST_COR        0
`define PUE_DST_NF         1
`define PUE_DST_FAT        2
`define PUE_DST_UR         3
`define PUE_CPL_ST_UR      3'h1
`define PUE_CPL_ST_CA      3'h4

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define PUE_RST_CTRL       5'h00
`define PUE_RST_DEV_ID     16'h0000
`define PUE_RST_UNC_SEV    32'h00062030
`define PUE_RST_COR_MASK   32'h00002000
`define PUE_CPL_DEPTH      4
`define PUE_PEND_W         4

`endif

/* hw/pue_pkg.sv */
// Types of the user error reporting block
package pue_pkg;

  typedef enum logic [1:0] {
    PUE_MSG_NONE = 2'h0,
    PUE_MSG_COR  = 2'h1,
    PUE_MSG_NF   = 2'h2,
    PUE_MSG_FAT  = 2'h3
  } pue_msg_kind_t;

  typedef struct packed {
    logic ur;
    logic cpl_abort;
    logic ecrc;
    logic malformed;
    logic mc_block;
    logic poisoned;
    logic cpl_timeout;
    logic cpl_unexpect;
    logic posted;
    logic no_recovery;
  } pue_err_rpt_t;

  typedef struct packed {
    logic [47:0] hdr;
    logic [2:0]  status;
  } pue_cpl_entry_t;

endpackage : pue_pkg

/* hw/pue_pend_cnt.sv */
// Pending message counter, one per message kind
`timescale 1ns/10ps
`default_nettype none
module pue_pend_cnt #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [3:0]   inc_i,
  input  wire logic         dec_i,
  output logic              busy_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W:0]   sum;

  assign sum    = {1'b0, cnt_q} + (W+1)'(inc_i) - (W+1)'(dec_i);
  // Saturate rather than wrap
  assign cnt_d  = sum[W] ? {W{1'b1}} : sum[W-1:0];
  assign busy_o = |cnt_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

endmodule : pue_pend_cnt
`default_nettype wire

/* hw/pue_top.sv */
// Error reporting side port: classification, status, messages, completions
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "pue_defs.svh"
module pue_top #(
  parameter int CPL_DEPTH = `PUE_CPL_DEPTH,
  parameter int PEND_W    = `PUE_PEND_W
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Register port
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [31:0]                 reg_rdata_o,
  // User error reports
  input  wire pue_pkg::pue_err_rpt_t  rpt_i,
  input  wire logic [47:0]            tlp_cpl_hdr_i,
  input  wire logic [127:0]           hdr_log_i,
  output logic                        cpl_rdy_o,
  output logic                        hdr_logged_o,
  // Inbound completions
  input  wire logic                   rx_cpl_valid_i,
  input  wire logic [15:0]            rx_cpl_req_id_i,
  output logic                        usr_cpl_valid_o,
  // Error messages toward transmit
  output logic                        msg_valid_o,
  output pue_pkg::pue_msg_kind_t      msg_kind_o,
  input  wire logic                   msg_ready_i,
  // Non-successful completions toward transmit
  output logic                        cpl_valid_o,
  output pue_pkg::pue_cpl_entry_t     cpl_o,
  input  wire logic                   cpl_ready_i
);

  localparam int NSRC = 8;
  localparam int CW   = $clog2(CPL_DEPTH + 1);
  localparam int AW   = (CPL_DEPTH > 1) ? $clog2(CPL_DEPTH) : 1;
  localparam logic [4:0] UNC_POS [NSRC] = '{
    `PUE_UNC_UNSUP_REQ, `PUE_UNC_CPL_ABORT, `PUE_UNC_ECRC, `PUE_UNC_MALFORMED,
    `PUE_UNC_MC_BLOCK, `PUE_UNC_POISONED, `PUE_UNC_CPL_TO, `PUE_UNC_UNEXP_CPL};

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [`PUE_CTRL_W-1:0] ctrl_q;
  logic [15:0]            dev_id_q;
  logic [31:0]            unc_stat_q;
  logic [31:0]            unc_mask_q;
  logic [31:0]            unc_sev_q;
  logic [31:0]            cor_stat_q;
  logic [31:0]            cor_mask_q;
  logic [3:0]             dev_stat_q;
  logic [4:0]             fep_q;
  logic                   hl_set_q;
  logic [127:0]           hdr_log_q;
  logic [31:0]            rdata_q;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_ctrl     = reg_wr_i && (reg_addr_i == `PUE_ADDR_CTRL);
  wire wr_id       = reg_wr_i && (reg_addr_i == `PUE_ADDR_DEV_ID);
  wire wr_unc_stat = reg_wr_i && (reg_addr_i == `PUE_ADDR_UNC_STAT);
  wire wr_unc_mask = reg_wr_i && (reg_addr_i == `PUE_ADDR_UNC_MASK);
  wire wr_unc_sev  = reg_wr_i && (reg_addr_i == `PUE_ADDR_UNC_SEV);
  wire wr_cor_stat = reg_wr_i && (reg_addr_i == `PUE_ADDR_COR_STAT);
  wire wr_cor_mask = reg_wr_i && (reg_addr_i == `PUE_ADDR_COR_MASK);
  wire wr_dev_stat = reg_wr_i && (reg_addr_i == `PUE_ADDR_DEV_STAT);

  wire aer_en  = ctrl_q[`PUE_CTRL_AER_EN];
  wire serr_en = ctrl_q[`PUE_CTRL_SERR_EN];
  wire cor_en  = ctrl_q[`PUE_CTRL_COR_EN];
  wire nf_en   = ctrl_q[`PUE_CTRL_NF_EN] || serr_en;
  wire fat_en  = ctrl_q[`PUE_CTRL_FAT_EN] || serr_en;

  logic [31:0] rd_mux;
  always_comb
  begin
    case (reg_addr_i)
      `PUE_ADDR_CTRL:     rd_mux = {{(32-`PUE_CTRL_W){1'b0}}, ctrl_q};
      `PUE_ADDR_DEV_ID:   rd_mux = {16'h0000, dev_id_q};
      `PUE_ADDR_UNC_STAT: rd_mux = unc_stat_q;
      `PUE_ADDR_UNC_MASK: rd_mux = unc_mask_q;
      `PUE_ADDR_UNC_SEV:  rd_mux = unc_sev_q;
      `PUE_ADDR_COR_STAT: rd_mux = cor_stat_q;
      `PUE_ADDR_COR_MASK: rd_mux = cor_mask_q;
      `PUE_ADDR_ERR_CAP:  rd_mux = {26'h0000000, hl_set_q, fep_q};
      `PUE_ADDR_DEV_STAT: rd_mux = {28'h0000000, dev_stat_q};
      `PUE_ADDR_HDR_LOG0: rd_mux = hdr_log_q[127:96];
      `PUE_ADDR_HDR_LOG1: rd_mux = hdr_log_q[95:64];
      `PUE_ADDR_HDR_LOG2: rd_mux = hdr_log_q[63:32];
      `PUE_ADDR_HDR_LOG3: rd_mux = hdr_log_q[31:0];
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Report classification
  // ----------------------------------------------------------------
  // Reports are taken in the cycle they are high, with their qualifiers
  wire [NSRC-1:0] src_hit = {rpt_i.cpl_unexpect, rpt_i.cpl_timeout, rpt_i.poisoned,
                             rpt_i.mc_block, rpt_i.malformed, rpt_i.ecrc,
                             rpt_i.cpl_abort, rpt_i.ur};
  // Advisory cases: non-posted UR/CA, recoverable poison, user unexpected
  wire [NSRC-1:0] src_adv = {1'b1, 1'b0, !rpt_i.no_recovery, 1'b0, 1'b0, 1'b0,
                             !rpt_i.posted, !rpt_i.posted};
  // Only malformed escalates to fatal with AER off
  wire [NSRC-1:0] src_fat = {4'h0, 1'b1, 3'h0};
  // Automatic unexpected completion: foreign requester ID
  wire auto_unexp = rx_cpl_valid_i && (rx_cpl_req_id_i != dev_id_q);

  logic [NSRC-1:0] is_cor;
  logic [NSRC-1:0] is_nf;
  logic [NSRC-1:0] is_fat;
  logic [NSRC-1:0] sd_cor;
  logic [NSRC-1:0] sd_nf;
  logic [NSRC-1:0] sd_fat;

  for (genvar i = 0; i < NSRC; i++)
  begin : g_cls
    wire sev = unc_sev_q[UNC_POS[i]];
    wire msk = unc_mask_q[UNC_POS[i]];
    wire sev_cls = src_hit[i] && !src_adv[i];
    // AER gives severity and mask; without it fixed classes apply
    assign is_cor[i] = src_hit[i] && src_adv[i] && aer_en;
    assign is_fat[i] = sev_cls && (aer_en ? sev : src_fat[i]);
    assign is_nf[i]  = sev_cls && (aer_en ? !sev : !src_fat[i]);
    // Messages gated by mask and enables; status is not
    assign sd_cor[i] = is_cor[i] && !cor_mask_q[`PUE_COR_ADVISORY] && cor_en;
    assign sd_nf[i]  = is_nf[i] && !(aer_en && msk) && nf_en;
    assign sd_fat[i] = is_fat[i] && !(aer_en && msk) && fat_en;
  end : g_cls

  // ----------------------------------------------------------------
  // Status updates
  // ----------------------------------------------------------------
  logic [31:0] unc_set;
  logic [4:0]  first_pos;
  logic        any_new;
  always_comb
  begin
    unc_set   = 32'h00000000;
    first_pos = 5'h00;
    any_new   = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (src_hit[i])
      begin
        unc_set[UNC_POS[i]] = 1'b1;
        first_pos = UNC_POS[i];
        any_new   = 1'b1;
      end
    end
    if (auto_unexp)
    begin
      unc_set[`PUE_UNC_UNEXP_CPL] = 1'b1;
    end
  end

  wire cor_adv_set = (|is_cor) || auto_unexp;
  wire [3:0] dev_set = {rpt_i.ur, |is_fat, |is_nf, |is_cor};

  // Set wins over a clear in the same cycle
  wire [31:0] unc_stat_d = (unc_stat_q & ~(wr_unc_stat ? reg_wdata_i : 32'h00000000))
                           | unc_set;
  wire [31:0] cor_stat_d = (cor_stat_q & ~(wr_cor_stat ? reg_wdata_i : 32'h00000000))
                           | (32'(cor_adv_set) << `PUE_COR_ADVISORY);
  wire [3:0]  dev_stat_d = (dev_stat_q & ~(wr_dev_stat ? reg_wdata_i[3:0] : 4'h0))
                           | dev_set;

  // Header is kept while one is held; released when pointer bit clears
  wire hl_capture = any_new && !hl_set_q;
  wire hl_release = hl_set_q && !unc_stat_q[fep_q];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q     <= `PUE_RST_CTRL;
      dev_id_q   <= `PUE_RST_DEV_ID;
      unc_stat_q <= 32'h00000000;
      unc_mask_q <= 32'h00000000;
      unc_sev_q  <= `PUE_RST_UNC_SEV;
      cor_stat_q <= 32'h00000000;
      cor_mask_q <= `PUE_RST_COR_MASK;
      dev_stat_q <= 4'h0;
      rdata_q    <= 32'h00000000;
    end
    else
    begin
      if (wr_ctrl) ctrl_q <= reg_wdata_i[`PUE_CTRL_W-1:0];
      if (wr_id) dev_id_q <= reg_wdata_i[15:0];
      if (wr_unc_mask) unc_mask_q <= reg_wdata_i;
      if (wr_unc_sev) unc_sev_q <= reg_wdata_i;
      if (wr_cor_mask) cor_mask_q <= reg_wdata_i;
      unc_stat_q <= unc_stat_d;
      cor_stat_q <= cor_stat_d;
      dev_stat_q <= dev_stat_d;
      rdata_q    <= reg_rd_i ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hl_set_q  <= 1'b0;
      fep_q     <= 5'h00;
      hdr_log_q <= '0;
    end
    else if (hl_capture)
    begin
      hl_set_q  <= 1'b1;
      fep_q     <= first_pos;
      hdr_log_q <= hdr_log_i;
    end
    else if (hl_release)
    begin
      hl_set_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Message queue
  // ----------------------------------------------------------------
  // Every report of a cycle is counted; counts saturate at the counter maximum
  logic [2:0] pend_busy;
  logic [2:0] pend_dec;
  logic [3:0] pend_inc [3];
  assign pend_inc[0] = 4'($countones(sd_cor));
  assign pend_inc[1] = 4'($countones(sd_nf));
  assign pend_inc[2] = 4'($countones(sd_fat));

  for (genvar k = 0; k < 3; k++)
  begin : g_pend
    pue_pend_cnt #(
      .W (PEND_W)
    ) u_pend (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .inc_i  (pend_inc[k]),
      .dec_i  (pend_dec[k]),
      .busy_o (pend_busy[k])
    );
  end : g_pend

  logic                   msg_valid_q;
  pue_pkg::pue_msg_kind_t msg_kind_q;
  wire msg_free = !msg_valid_q || msg_ready_i;
  // Fatal first, then non-fatal, then correctable
  assign pend_dec[2] = msg_free && pend_busy[2];
  assign pend_dec[1] = msg_free && !pend_busy[2] && pend_busy[1];
  assign pend_dec[0] = msg_free && !pend_busy[2] && !pend_busy[1] && pend_busy[0];
  wire pue_pkg::pue_msg_kind_t msg_next =
    pend_dec[2] ? pue_pkg::PUE_MSG_FAT :
    pend_dec[1] ? pue_pkg::PUE_MSG_NF :
    pend_dec[0] ? pue_pkg::PUE_MSG_COR : pue_pkg::PUE_MSG_NONE;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      msg_valid_q <= 1'b0;
      msg_kind_q  <= pue_pkg::PUE_MSG_NONE;
    end
    else if (msg_free)
    begin
      msg_valid_q <= |pend_dec;
      msg_kind_q  <= msg_next;
    end
  end

  // ----------------------------------------------------------------
  // Completion queue
  // ----------------------------------------------------------------
  pue_pkg::pue_cpl_entry_t cq_mem [CPL_DEPTH];
  logic [AW-1:0]           wr_ptr_q;
  logic [AW-1:0]           rd_ptr_q;
  logic [CW-1:0]           cnt_q;
  logic                    rdy_q;
  logic                    cpl_valid_q;
  pue_pkg::pue_cpl_entry_t cpl_q;

  // Non-posted UR or CA; UR wins if both arrive together
  wire np_ur  = rpt_i.ur && !rpt_i.posted;
  wire np_ca  = rpt_i.cpl_abort && !rpt_i.posted;
  wire cq_push = (np_ur || np_ca) && (cnt_q < CW'(CPL_DEPTH));
  wire cq_pop  = (cnt_q != '0) && (!cpl_valid_q || cpl_ready_i);
  wire [CW-1:0] cnt_d = cnt_q + CW'(cq_push) - CW'(cq_pop);
  wire pue_pkg::pue_cpl_entry_t cq_in = '{hdr: tlp_cpl_hdr_i,
    status: np_ur ? `PUE_CPL_ST_UR : `PUE_CPL_ST_CA};
  wire [AW-1:0] wr_ptr_inc = (wr_ptr_q == AW'(CPL_DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
  wire [AW-1:0] rd_ptr_inc = (rd_ptr_q == AW'(CPL_DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);

  always_ff @(posedge clk_i)
  begin
    if (cq_push) cq_mem[wr_ptr_q] <= cq_in;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      cnt_q       <= '0;
      rdy_q       <= 1'b0;
      cpl_valid_q <= 1'b0;
      cpl_q       <= '0;
    end
    else
    begin
      if (cq_push) wr_ptr_q <= wr_ptr_inc;
      if (cq_pop) rd_ptr_q <= rd_ptr_inc;
      cnt_q <= cnt_d;
      // Ready low as soon as no slot is left
      rdy_q <= (cnt_d < CW'(CPL_DEPTH));
      if (cq_pop)
      begin
        cpl_valid_q <= 1'b1;
        cpl_q       <= cq_mem[rd_ptr_q];
      end
      else if (cpl_ready_i)
      begin
        cpl_valid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Inbound completion filter
  // ----------------------------------------------------------------
  logic usr_cpl_q;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      usr_cpl_q <= 1'b0;
    end
    else
    begin
      usr_cpl_q <= rx_cpl_valid_i && !auto_unexp;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o     = rdata_q;
  assign cpl_rdy_o       = rdy_q;
  assign hdr_logged_o    = hl_set_q;
  assign usr_cpl_valid_o = usr_cpl_q;
  assign msg_valid_o     = msg_valid_q;
  assign msg_kind_o      = msg_kind_q;
  assign cpl_valid_o     = cpl_valid_q;
  assign cpl_o           = cpl_q;

endmodule : pue_top
`default_nettype wire

/* verification/pue_checker.sv */
// Port assertions of the error reporting block
`timescale 1ns/10ps
`default_nettype none
module pue_checker #(
  parameter int CPL_DEPTH = 4,
  parameter int PEND_W    = 4
) (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic [7:0]              reg_addr_i,
  input wire logic [31:0]             reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire pue_pkg::pue_err_rpt_t   rpt_i,
  input wire logic [47:0]             tlp_cpl_hdr_i,
  input wire logic                    cpl_rdy_o,
  input wire logic                    hdr_logged_o,
  input wire logic                    msg_valid_o,
  input wire pue_pkg::pue_msg_kind_t  msg_kind_o,
  input wire logic                    msg_ready_i,
  input wire logic                    cpl_valid_o,
  input wire pue_pkg::pue_cpl_entry_t cpl_o,
  input wire logic                    cpl_ready_i
);
  // ----
  // Control shadow and properties
  // ----
  logic [4:0] ctrl_q;
  wire        np_urca = (rpt_i.ur || rpt_i.cpl_abort) && !rpt_i.posted;
  wire        unc_clr = reg_wr_i && reg_addr_i == 8'h08;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      ctrl_q <= 5'h00;
    else if (reg_wr_i && reg_addr_i == 8'h00)
      ctrl_q <= reg_wdata_i[4:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_np_first;
    np_urca && cpl_rdy_o && !cpl_valid_o && !$past(np_urca);
  endsequence
  sequence s_cpl_out;
    cpl_valid_o && cpl_o.hdr == $past(tlp_cpl_hdr_i, 2) &&
      cpl_o.status == ($past(rpt_i.ur, 2) ? 3'h1 : 3'h4);
  endsequence
  AST_MSG_HOLD: assert property (
    msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_kind_o))
    else $error("message withdrawn");
  AST_CPL_HOLD: assert property (
    cpl_valid_o && !cpl_ready_i |=> cpl_valid_o && $stable(cpl_o))
    else $error("completion withdrawn");
  AST_MSG_KIND: assert property (
    msg_valid_o |-> msg_kind_o != pue_pkg::PUE_MSG_NONE)
    else $error("message without kind");
  AST_CPL_CODE: assert property (
    cpl_valid_o |-> cpl_o.status inside {3'h1, 3'h4})
    else $error("bad completion status");
  AST_NP_CPL: assert property (
    s_np_first |-> ##2 s_cpl_out)
    else $error("completion late or wrong");
  AST_MALF_FATAL: assert property (
    rpt_i.malformed && !ctrl_q[0] && ctrl_q[3] && !msg_valid_o ##1 msg_ready_i
      |=> msg_valid_o && msg_kind_o == pue_pkg::PUE_MSG_FAT)
    else $error("no fatal message");
  AST_ADV_QUIET: assert property (
    rpt_i[9:2] == 8'h04 && !rpt_i.no_recovery && !ctrl_q[0] && !msg_valid_o
      && $past(rpt_i) == 10'h000 |=> !msg_valid_o [*2])
    else $error("advisory sent a message");
  AST_HDR_HOLD: assert property (
    hdr_logged_o && !unc_clr && !$past(unc_clr) |=> hdr_logged_o)
    else $error("header flag fell early");
endmodule : pue_checker
`default_nettype wire

/* verification/pue_tx_model.sv */
// Transmit-side partner: takes messages and completions, logs them
`timescale 1ns/10ps
`default_nettype none
module pue_tx_model (
  input  wire logic                    clk_i,
  input  wire logic                    stall_i,
  input  wire logic                    msg_valid_i,
  input  wire pue_pkg::pue_msg_kind_t  msg_kind_i,
  output logic                         msg_ready_o,
  input  wire logic                    cpl_valid_i,
  input  wire pue_pkg::pue_cpl_entry_t cpl_i,
  output logic                         cpl_ready_o
);
  // ----
  // Acceptance and log
  // ----
  int                      n_msg = 0;
  int                      n_cpl = 0;
  pue_pkg::pue_msg_kind_t  last_kind;
  pue_pkg::pue_cpl_entry_t cpl_log[16];
  assign msg_ready_o = !stall_i;
  assign cpl_ready_o = !stall_i;
  always @(posedge clk_i)
  begin
    if (msg_valid_i && msg_ready_o)
    begin
      n_msg     <= n_msg + 1;
      last_kind <= msg_kind_i;
    end
    if (cpl_valid_i && cpl_ready_o && n_cpl < 16)
    begin
      cpl_log[n_cpl] <= cpl_i;
      n_cpl          <= n_cpl + 1;
    end
  end
endmodule : pue_tx_model
`default_nettype wire

/* verification/tb.sv */
// Testbench of the error reporting block
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ----
  // Signals and instances
  // ----
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    reg_wr_i = 1'b0, reg_rd_i = 1'b0, rx_cpl_valid_i = 1'b0;
  logic                    stall = 1'b0, full;
  logic [7:0]              reg_addr_i = 8'h00;
  logic [31:0]             reg_wdata_i = 32'h0, rd_data, reg_rdata_o;
  logic [15:0]             rx_cpl_req_id_i = 16'h0;
  logic [47:0]             tlp_cpl_hdr_i = 48'h0;
  logic [127:0]            hdr_log_i = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  pue_pkg::pue_err_rpt_t   rpt_i = '0;
  logic                    cpl_rdy_o, hdr_logged_o, usr_cpl_valid_o, msg_valid_o;
  logic                    msg_ready_i, cpl_valid_o, cpl_ready_i;
  pue_pkg::pue_msg_kind_t  msg_kind_o;
  pue_pkg::pue_cpl_entry_t cpl_o;
  int                      failures = 0, n_tests = 0, n_usr = 0, n0, u0, sent, k;
  pue_top i_pue_top (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .rpt_i, .tlp_cpl_hdr_i, .hdr_log_i, .cpl_rdy_o, .hdr_logged_o,
    .rx_cpl_valid_i, .rx_cpl_req_id_i, .usr_cpl_valid_o, .msg_valid_o, .msg_kind_o,
    .msg_ready_i, .cpl_valid_o, .cpl_o, .cpl_ready_i);
  pue_tx_model i_pue_tx_model (.clk_i, .stall_i(stall), .msg_valid_i(msg_valid_o),
    .msg_kind_i(msg_kind_o), .msg_ready_o(msg_ready_i), .cpl_valid_i(cpl_valid_o),
    .cpl_i(cpl_o), .cpl_ready_o(cpl_ready_i));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (usr_cpl_valid_o === 1'b1) n_usr++;
  // ----
  // Bus tasks and compare
  // ----
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    rd_data = reg_rdata_o;
  endtask : rd
  task automatic rx(input logic [15:0] id);
    @(posedge clk_i);
    rx_cpl_valid_i  <= 1'b1;
    rx_cpl_req_id_i <= id;
    @(posedge clk_i);
    rx_cpl_valid_i <= 1'b0;
  endtask : rx
  task automatic run_case(input logic [9:0] r, input logic [4:0] c, input logic [1:0] kind);
    wr(8'h00, {27'h0, c});
    n0 = i_pue_tx_model.n_msg;
    @(posedge clk_i);
    rpt_i <= pue_pkg::pue_err_rpt_t'(r);
    @(posedge clk_i);
    rpt_i <= '0;
    repeat (8) @(posedge clk_i);
    chk(64'(i_pue_tx_model.n_msg - n0), {63'h0, kind != 2'h0});
    if (kind != 2'h0) chk(64'(i_pue_tx_model.last_kind), 64'(kind));
    $display("case %h done", r);
  endtask : run_case
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h10);
    chk(64'(cpl_rdy_o), 64'h1);
    chk(64'(rd_data), 64'h0006_2030);
    rd(8'h40);
    chk(64'(rd_data), 64'h0);
    wr(8'h18, 32'h0);
    run_case(10'h040, 5'h08, 2'h3);
    run_case(10'h020, 5'h04, 2'h2);
    run_case(10'h011, 5'h04, 2'h2);
    run_case(10'h010, 5'h0E, 2'h0);
    run_case(10'h004, 5'h0E, 2'h0);
    run_case(10'h202, 5'h04, 2'h2);
    run_case(10'h008, 5'h04, 2'h2);
    run_case(10'h040, 5'h0F, 2'h3);
    run_case(10'h020, 5'h0F, 2'h2);
    run_case(10'h010, 5'h03, 2'h1);
    run_case(10'h040, 5'h00, 2'h0);
    wr(8'h0C, 32'h0080_0000);
    run_case(10'h020, 5'h0F, 2'h0);
    rd(8'h30);
    chk(64'(rd_data), 64'h7654_3210);
    chk(64'(hdr_logged_o), 64'h1);
    rd(8'h08);
    chk(64'(rd_data[18]), 64'h1);
    wr(8'h08, 32'hFFFF_FFFF);
    @(posedge clk_i);
    @(negedge clk_i);
    chk(64'(hdr_logged_o), 64'h0);
    $display("header test done");
    @(posedge clk_i);
    stall <= 1'b1;
    sent = 0;
    full = 1'b0;
    for (k = 0; k < 8 && !full; k++)
    begin
      @(negedge clk_i);
      full = !cpl_rdy_o;
      @(posedge clk_i);
      rpt_i <= pue_pkg::pue_err_rpt_t'(full ? 10'h0 : k == 0 ? 10'h100 : 10'h200);
      tlp_cpl_hdr_i <= 48'hA000_0000_0000 + 48'(k);
      sent += int'(!full);
      @(posedge clk_i);
      rpt_i <= '0;
    end
    @(posedge clk_i);
    rpt_i <= '0;
    stall <= 1'b0;
    chk(64'(full), 64'h1);
    for (k = 0; k < 50 && i_pue_tx_model.n_cpl < sent; k++)
      @(posedge clk_i);
    chk(64'(i_pue_tx_model.n_cpl), 64'(sent));
    for (k = 0; k < sent; k++)
      chk(64'(i_pue_tx_model.cpl_log[k]),
        {13'h0, 48'hA000_0000_0000 + 48'(k), k == 0 ? 3'h4 : 3'h1});
    $display("completion test done");
    wr(8'h04, 32'h0000_00AB);
    wr(8'h14, 32'hFFFF_FFFF);
    n0 = i_pue_tx_model.n_msg;
    u0 = n_usr;
    rx(16'h00AB);
    rx(16'h00CD);
    repeat (4) @(posedge clk_i);
    chk(64'(n_usr - u0), 64'h1);
    chk(64'(i_pue_tx_model.n_msg - n0), 64'h0);
    rd(8'h08);
    chk(64'(rd_data[16]), 64'h1);
    rd(8'h14);
    chk(64'(rd_data[13]), 64'h1);
    $display("inbound test done");
    print_verdict();
  end
endmodule : tb
bind pue_top pue_checker #(.CPL_DEPTH(CPL_DEPTH), .PEND_W(PEND_W)) i_pue_checker (.clk_i,
  .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .rpt_i, .tlp_cpl_hdr_i, .cpl_rdy_o,
  .hdr_logged_o, .msg_valid_o, .msg_kind_o, .msg_ready_i, .cpl_valid_o, .cpl_o, .cpl_ready_i);
`default_nettype wire
